// >>> rtl/ams_map.vh
// Constants for the asynchronous memory access sequencer.
// Included by the sequencer; definitions only.
`ifndef AMS_MAP_VH
`define AMS_MAP_VH
// Field widths of the chip space configuration
`define AMS_SETUP_W 4
`define AMS_STROBE_W 6
`define AMS_HOLD_W 3
`define AMS_TA_W 2
// Field positions within chip_space_config
`define AMS_CFG_SS_BIT 31
`define AMS_CFG_WSU_LSB 26
`define AMS_CFG_WST_LSB 20
`define AMS_CFG_WHD_LSB 17
`define AMS_CFG_RSU_LSB 13
`define AMS_CFG_RST_LSB 7
`define AMS_CFG_RHD_LSB 4
`define AMS_CFG_TA_LSB 2
`define AMS_CFG_WIDE_BIT 0
// Reset value of the chip space configuration
`define AMS_CFG_RESET 32'h3FFFFFFD
// Depth of the read data FIFO
`define AMS_FIFO_DEPTH 8
`endif

// >>> rtl/ams_fifo.v
// Synchronous FIFO with valid and ready on both sides.
// Single clock; width and depth are parameters, depth a power of two.
module ams_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_in,
  input wire reset_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire push;
  wire pop;

  // Full and empty from pointer wrap bits
  assign in_ready_out = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
  assign out_valid_out = (wr_ptr_reg != rd_ptr_reg);
  assign out_data_out = mem[rd_ptr_reg[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Storage write
  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end

  // Pointers
  always @(posedge clk_in) begin
    if (reset_in) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule // ams_fifo

// >>> rtl/ams_sequencer.v
// Asynchronous memory access sequencer: turnaround, setup, strobe, hold.
// Assumes an arbiter presents the top-priority request on req_* and keeps
// req_valid_in high while that request stays top priority. Read words go
// through an 8-word FIFO; writes need no buffer.
// Overview of operation
// R1: Normal-mode read: output enable low through strobe, released at strobe end.
// R2: Read data captured at the edge ending the strobe; device must be valid.
// R3: Wait input stretches the strobe while it is active; the sequencer sees it four cycles late and holds only the last strobe cycle.
// R4: Normal mode: address invalid after hold; select rises only after last access.
// R5: Follow-on accesses of a word go straight to setup, no turnaround.
// R6: Follow-on accesses keep the timing counts loaded at the first access.
// R7: After a word, return idle or go straight to next request's turnaround.
// R8: Output enable stays high throughout every write access.
// R9: Write strobe stays high throughout every read access.
// R10: Start only on top-priority request; repeat accesses until fully served.
// R11: Write waits turnaround; none after write, one after read when field zero.
// R12: Read waits turnaround; none after read, one after write when field zero.
// R13: After turnaround, recheck priority; proceed to setup or abandon.
// R14: Normal mode: setup drives address, write data, select if not already low.
// R15: Normal write: write strobe and byte enables active only during strobe.
// R16: Write data stops being driven at end of hold, with the address.
// R17: Select-strobe bit one: select only during strobe, byte enables as enables.
// R18: Select-strobe read: byte enables valid from setup with the address.
// R19: Select-strobe read: select and output enable together over the strobe.
// R20: Select-strobe read: byte enables invalid at end of hold.
// R21: Setup loads setup, strobe, hold counts from config by direction.
// R22: Strobe width is strobe field plus one cycle.
// R23: Hold lasts hold field plus one cycle after strobe rises.
// R24: Select-strobe bit zero selects normal mode, the default.
// R25: Turnaround is the field plus one cycle between reads and writes.
// R26: Take request with direction, address, byte count; signal done at end.
`include "ams_map.vh"
module ams_sequencer #(
  parameter ADDR_W = 23,
  parameter CNT_W = 3
) (
  input wire clk_in,
  input wire reset_in,
  input wire [31:0] chip_space_config_in,
  input wire req_valid_in,
  input wire req_write_in,
  input wire [ADDR_W-1:0] req_addr_in,
  input wire [CNT_W-1:0] req_bytes_in,
  input wire [31:0] req_wdata_in,
  output wire req_taken_out,
  output reg req_done_out,
  output reg req_abandon_out,
  output wire rd_valid_out,
  input wire rd_ready_in,
  output wire [31:0] rd_data_out,
  output reg [ADDR_W-1:0] ext_address_lines_out,
  output reg [1:0] ext_bank_address_lines_out,
  input wire [15:0] ext_data_bus_in,
  output reg [15:0] ext_data_bus_out,
  output reg ext_data_bus_oe_out,
  output reg async_chip_select_n_out,
  output reg async_output_enable_n_out,
  output reg async_write_strobe_n_out,
  output reg [1:0] byte_enable_n_out,
  input wire ext_wait_input_in,
  output wire busy_out
);
  localparam ST_IDLE = 3'h0;
  localparam ST_TA = 3'h1;
  localparam ST_SETUP = 3'h2;
  localparam ST_STROBE = 3'h3;
  localparam ST_HOLD = 3'h4;

  reg [2:0] state_reg;
  reg [7:0] cnt_reg;
  reg [`AMS_SETUP_W-1:0] setup_reg;
  reg [`AMS_STROBE_W-1:0] strobe_reg;
  reg [`AMS_HOLD_W-1:0] hold_reg;
  reg write_reg;
  reg ss_reg;
  reg wide_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [CNT_W-1:0] left_reg;
  reg [31:0] wdata_reg;
  reg [31:0] rdata_reg;
  reg [1:0] lane_reg;
  reg last_valid_reg;
  reg last_write_reg;
  reg push_reg;
  reg [2:0] wait_sync_reg;
  reg wait_reg;
  wire wait_act;
  wire fifo_ready;
  wire last_access;
  wire [`AMS_TA_W-1:0] ta_field;
  wire [`AMS_SETUP_W-1:0] wsu_field;
  wire [`AMS_STROBE_W-1:0] wst_field;
  wire [`AMS_HOLD_W-1:0] whd_field;
  wire [`AMS_SETUP_W-1:0] rsu_field;
  wire [`AMS_STROBE_W-1:0] rst_field;
  wire [`AMS_HOLD_W-1:0] rhd_field;

  // Wait pin synchroniser; a change counts when stages two and three agree
  always @(posedge clk_in) begin
    if (reset_in) begin
      wait_sync_reg <= 3'h0;
      wait_reg <= 1'b0;
    end else begin
      wait_sync_reg <= {wait_sync_reg[1:0], ext_wait_input_in};
      if (wait_sync_reg[1] == wait_sync_reg[2]) begin
        wait_reg <= wait_sync_reg[2];
      end
    end
  end
  assign wait_act = wait_reg;

  // Lane width in bytes and end-of-word test
  function [CNT_W-1:0] lane_bytes;
    input wide;
    begin
      lane_bytes = wide ? 3'h2 : 3'h1;
    end
  endfunction

  // Write data for the lane after the current one
  function [15:0] lane_data;
    input wide;
    input [1:0] lane;
    input [31:0] word;
    begin
      if (wide) begin
        lane_data = word[31:16];
      end else if (lane == 2'h0) begin
        lane_data = {8'h00, word[15:8]};
      end else if (lane == 2'h1) begin
        lane_data = {8'h00, word[23:16]};
      end else begin
        lane_data = {8'h00, word[31:24]};
      end
    end
  endfunction

  assign ta_field = chip_space_config_in[`AMS_CFG_TA_LSB+`AMS_TA_W-1:`AMS_CFG_TA_LSB];
  // Timing fields by direction, sampled live from the configuration
  assign wsu_field = chip_space_config_in[`AMS_CFG_WSU_LSB+`AMS_SETUP_W-1:`AMS_CFG_WSU_LSB];
  assign wst_field = chip_space_config_in[`AMS_CFG_WST_LSB+`AMS_STROBE_W-1:`AMS_CFG_WST_LSB];
  assign whd_field = chip_space_config_in[`AMS_CFG_WHD_LSB+`AMS_HOLD_W-1:`AMS_CFG_WHD_LSB];
  assign rsu_field = chip_space_config_in[`AMS_CFG_RSU_LSB+`AMS_SETUP_W-1:`AMS_CFG_RSU_LSB];
  assign rst_field = chip_space_config_in[`AMS_CFG_RST_LSB+`AMS_STROBE_W-1:`AMS_CFG_RST_LSB];
  assign rhd_field = chip_space_config_in[`AMS_CFG_RHD_LSB+`AMS_HOLD_W-1:`AMS_CFG_RHD_LSB];

  assign last_access = (left_reg <= lane_bytes(wide_reg));
  // No take while a read word is still on its way into the buffer,
  // else a full buffer could be seen as ready one cycle too early
  assign req_taken_out = (state_reg == ST_IDLE) && req_valid_in && fifo_ready && !push_reg; // R10 R26
  assign busy_out = (state_reg != ST_IDLE);

  // Access sequencer
  always @(posedge clk_in) begin
    if (reset_in) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      setup_reg <= {`AMS_SETUP_W{1'b0}};
      strobe_reg <= {`AMS_STROBE_W{1'b0}};
      hold_reg <= {`AMS_HOLD_W{1'b0}};
      write_reg <= 1'b0;
      ss_reg <= 1'b0;
      wide_reg <= 1'b0;
      addr_reg <= {ADDR_W{1'b0}};
      left_reg <= {CNT_W{1'b0}};
      wdata_reg <= 32'h00000000;
      rdata_reg <= 32'h00000000;
      lane_reg <= 2'h0;
      last_valid_reg <= 1'b0;
      last_write_reg <= 1'b0;
      push_reg <= 1'b0;
      req_done_out <= 1'b0;
      req_abandon_out <= 1'b0;
      ext_address_lines_out <= {ADDR_W{1'b0}};
      ext_bank_address_lines_out <= 2'h0;
      ext_data_bus_out <= 16'h0000;
      ext_data_bus_oe_out <= 1'b0;
      async_chip_select_n_out <= 1'b1;
      async_output_enable_n_out <= 1'b1;
      async_write_strobe_n_out <= 1'b1;
      byte_enable_n_out <= 2'h3;
    end else begin
      push_reg <= 1'b0;
      req_done_out <= 1'b0;
      req_abandon_out <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (req_taken_out) begin
            write_reg <= req_write_in;
            addr_reg <= req_addr_in;
            left_reg <= req_bytes_in;
            wdata_reg <= req_wdata_in;
            rdata_reg <= 32'h00000000;
            lane_reg <= 2'h0;
            ss_reg <= chip_space_config_in[`AMS_CFG_SS_BIT]; // R17 R24
            wide_reg <= chip_space_config_in[`AMS_CFG_WIDE_BIT];
            // Turnaround only when direction changes; zero field gives one cycle
            if (last_valid_reg && (last_write_reg != req_write_in)) begin // R11 R12
              // Field plus one extra cycle over the plain recheck cycle
              cnt_reg <= {6'h00, ta_field} + 8'h01; // R25
              state_reg <= ST_TA;
            end else begin
              state_reg <= ST_TA;
              cnt_reg <= 8'hFF;
            end
          end
        end
        ST_TA: begin
          if (cnt_reg == 8'hFF || cnt_reg == 8'h00) begin
            // Priority recheck after turnaround
            if (req_valid_in) begin // R13
              state_reg <= ST_SETUP;
              if (write_reg) begin // R21
                setup_reg <= wsu_field;
                strobe_reg <= wst_field;
                hold_reg <= whd_field;
                cnt_reg <= {4'h0, wsu_field};
              end else begin
                setup_reg <= rsu_field;
                strobe_reg <= rst_field;
                hold_reg <= rhd_field;
                cnt_reg <= {4'h0, rsu_field};
              end
              // Address, write data and, in normal mode, select go valid at setup start
              ext_address_lines_out <= addr_reg; // R14
              ext_bank_address_lines_out <= addr_reg[1:0];
              ext_data_bus_out <= wdata_reg[15:0];
              ext_data_bus_oe_out <= write_reg; // R14
              if (!ss_reg) begin
                async_chip_select_n_out <= 1'b0; // R14
              end
              if (ss_reg && !write_reg) begin
                byte_enable_n_out <= 2'h0; // R18
              end
            end else begin
              state_reg <= ST_IDLE;
              req_abandon_out <= 1'b1; // R13
            end
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_SETUP: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= ST_STROBE;
            cnt_reg <= {2'h0, strobe_reg}; // R22
            if (write_reg) begin
              async_write_strobe_n_out <= 1'b0; // R15 R9
              byte_enable_n_out <= 2'h0; // R15
            end else begin
              async_output_enable_n_out <= 1'b0; // R1 R19 R8
            end
            if (ss_reg) begin
              async_chip_select_n_out <= 1'b0; // R17 R19
            end
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_STROBE: begin
          // Wait holds the strobe open at its last cycle
          // The pin reaches here four cycles late; short strobes may miss it
          if (cnt_reg == 8'h00 && !wait_act) begin // R3
            state_reg <= ST_HOLD;
            cnt_reg <= {5'h00, hold_reg}; // R23
            async_write_strobe_n_out <= 1'b1; // R15
            async_output_enable_n_out <= 1'b1; // R1 R19
            if (write_reg && !ss_reg) begin
              byte_enable_n_out <= 2'h3; // R15
            end
            if (ss_reg) begin
              async_chip_select_n_out <= 1'b1; // R19
            end
            if (!write_reg) begin
              // Capture read lane at the closing edge
              if (wide_reg) begin // R2
                rdata_reg[{lane_reg, 3'h0} +: 16] <= ext_data_bus_in;
              end else begin
                rdata_reg[{lane_reg, 3'h0} +: 8] <= ext_data_bus_in[7:0];
              end
            end
          end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_HOLD: begin
          if (cnt_reg == 8'h00) begin
            // End of hold: address, data and byte enables invalid
            ext_address_lines_out <= {ADDR_W{1'b0}}; // R4 R16
            ext_bank_address_lines_out <= 2'h0;
            ext_data_bus_oe_out <= 1'b0; // R16
            byte_enable_n_out <= 2'h3; // R20
            if (!last_access) begin
              // Next lane: straight to setup with counts kept
              state_reg <= ST_SETUP; // R5 R10
              cnt_reg <= {4'h0, setup_reg}; // R6
              left_reg <= left_reg - lane_bytes(wide_reg);
              lane_reg <= lane_reg + (wide_reg ? 2'h2 : 2'h1);
              addr_reg <= addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
              ext_address_lines_out <= addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
              ext_bank_address_lines_out <= addr_reg[1:0] + 2'h1;
              // Next lane's address and data replace the cleared ones at once
              ext_data_bus_out <= lane_data(wide_reg, lane_reg, wdata_reg);
              ext_data_bus_oe_out <= write_reg;
              if (ss_reg && !write_reg) begin
                byte_enable_n_out <= 2'h0;
              end
            end else begin
              // Word done; select rises, return to idle for next request
              state_reg <= ST_IDLE; // R7
              async_chip_select_n_out <= 1'b1; // R4
              req_done_out <= 1'b1; // R26
              // Read word enters the buffer one cycle after done
              push_reg <= !write_reg;
              last_valid_reg <= 1'b1;
              last_write_reg <= write_reg;
            end
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Read word buffer; a full buffer stalls new requests
  ams_fifo #(
    .WIDTH(32),
    .DEPTH(`AMS_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .in_valid_in(push_reg),
    .in_ready_out(fifo_ready),
    .in_data_in(rdata_reg),
    .out_valid_out(rd_valid_out),
    .out_ready_in(rd_ready_in),
    .out_data_out(rd_data_out)
  );
endmodule // ams_sequencer

// >>> testbench/ams_seq_props.sv
// Checker of the strobe, select and byte-enable sequencing.
// Bound to ams_sequencer; sees its ports only.
module ams_seq_props (
  input wire clk_in,
  input wire reset_in,
  input wire [31:0] chip_space_config_in,
  input wire req_taken_out,
  input wire req_done_out,
  input wire req_abandon_out,
  input wire busy_out,
  input wire ext_data_bus_oe_out,
  input wire async_chip_select_n_out,
  input wire async_output_enable_n_out,
  input wire async_write_strobe_n_out,
  input wire [1:0] byte_enable_n_out,
  input wire ext_wait_input_in
);
  wire ss = chip_space_config_in[31];
  wire oe_n = async_output_enable_n_out;
  wire we_n = async_write_strobe_n_out;
  wire str_n = oe_n & we_n;
  reg [7:0] low_cnt_reg;
  reg [3:0] wait_age_reg;
  wire quiet = wait_age_reg == 4'hF;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Strobe length so far, cycles since wait was last high
  always @(posedge clk_in) begin
    low_cnt_reg <= str_n ? 8'h00 : low_cnt_reg + 8'h01;
    if (reset_in || ext_wait_input_in) wait_age_reg <= reset_in ? 4'hF : 4'h0;
    else wait_age_reg <= wait_age_reg + {3'h0, !quiet};
  end
  property p_rd_no_wr; !oe_n |-> we_n && !ext_data_bus_oe_out; endproperty
  a_rd_no_wr: assert property (p_rd_no_wr) else $error("write during read strobe");
  property p_wr_no_rd; !we_n |-> oe_n; endproperty
  a_wr_no_rd: assert property (p_wr_no_rd) else $error("read enable during write");
  property p_norm_cs; !ss && !str_n |-> !async_chip_select_n_out; endproperty
  a_norm_cs: assert property (p_norm_cs) else $error("select off during strobe");
  property p_ss_cs; ss |-> async_chip_select_n_out == str_n; endproperty
  a_ss_cs: assert property (p_ss_cs) else $error("select not tied to strobe");
  property p_ss_be; ss && !oe_n |-> byte_enable_n_out != 2'h3; endproperty
  a_ss_be: assert property (p_ss_be) else $error("no byte enable in read");
  property p_nw_be; !ss && ext_data_bus_oe_out |-> (byte_enable_n_out != 2'h3) == !we_n; endproperty
  a_nw_be: assert property (p_nw_be) else $error("byte enable outside strobe");
  property p_rd_width; $rose(oe_n) |-> (quiet ? low_cnt_reg == chip_space_config_in[12:7] + 8'h01
    : low_cnt_reg >= chip_space_config_in[12:7] + 8'h01); endproperty
  a_rd_width: assert property (p_rd_width) else $error("read strobe width wrong");
  property p_wr_width; $rose(we_n) |-> (quiet ? low_cnt_reg == chip_space_config_in[25:20] + 8'h01
    : low_cnt_reg >= chip_space_config_in[25:20] + 8'h01); endproperty
  a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");
  property p_done_cs; req_done_out |-> async_chip_select_n_out && str_n; endproperty
  a_done_cs: assert property (p_done_cs) else $error("select low at done");
  property p_abandon; req_abandon_out |-> str_n && $past(str_n) && async_chip_select_n_out; endproperty
  a_abandon: assert property (p_abandon) else $error("strobe on dropped access");
  property p_hold; $fell(ext_data_bus_oe_out) |-> we_n && $past(we_n); endproperty
  a_hold: assert property (p_hold) else $error("write data dropped early");
  property p_taken; req_taken_out |=> busy_out; endproperty
  a_taken: assert property (p_taken) else $error("taken without busy");
endmodule // ams_seq_props

bind ams_sequencer ams_seq_props i_ams_seq_props (.clk_in, .reset_in, .chip_space_config_in,
  .req_taken_out, .req_done_out, .req_abandon_out, .busy_out, .ext_data_bus_oe_out,
  .async_chip_select_n_out, .async_output_enable_n_out, .async_write_strobe_n_out,
  .byte_enable_n_out, .ext_wait_input_in);

// >>> testbench/ams_mem_model.sv
// Model of an external asynchronous memory with a wait output.
// Words are keyed by low address and bank lines; single clock.
module ams_mem_model (
  input wire clk_in,
  input wire stretch_in,
  input wire [22:0] addr_in,
  input wire [1:0] bank_in,
  input wire [15:0] data_in,
  input wire cs_n_in,
  input wire oe_n_in,
  input wire we_n_in,
  input wire [1:0] be_n_in,
  output wire [15:0] data_out,
  output reg wait_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [15:0] mem [0:255];
  reg [15:0] junk_reg = 16'hA5A5;
  reg [2:0] wait_cnt_reg = 3'h0;
  wire [7:0] key = {addr_in[5:0], bank_in};
  // Stored word while read-selected, a changing pattern otherwise
  assign data_out = (!cs_n_in && !oe_n_in) ? mem[key] : junk_reg;
  // Store the enabled byte lanes while the write strobe is low
  always @(posedge clk_in) begin
    junk_reg <= ~junk_reg;
    if (!cs_n_in && !we_n_in) begin
      mem[key] <= {be_n_in[1] ? mem[key][15:8] : data_in[15:8],
        be_n_in[0] ? mem[key][7:0] : data_in[7:0]};
    end
  end
  // Hold wait high over the first strobe cycles when asked
  always @(posedge clk_in) begin
    if (oe_n_in && we_n_in) wait_cnt_reg <= 3'h0;
    else if (wait_cnt_reg < 3'h4) wait_cnt_reg <= wait_cnt_reg + 3'h1;
    wait_out <= stretch_in && !(oe_n_in && we_n_in) && wait_cnt_reg < 3'h4;
  end
endmodule // ams_mem_model

// >>> testbench/ams_sequencer_bench.sv
// Testbench: round trips words through the sequencer and a memory model.
// Requests are held until the strobe starts; read words are checked at the FIFO.
module ams_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, reset_in = 1, req_valid_in = 0, req_write_in = 0, rd_ready_in = 0;
  logic stretch = 0, hold_rd = 0;
  logic [31:0] chip_space_config_in = 32'h0, req_wdata_in = 32'h0;
  logic [22:0] req_addr_in = 23'h0;
  logic [2:0] req_bytes_in = 3'h4;
  wire req_taken_out, req_done_out, req_abandon_out, rd_valid_out, busy_out;
  wire [31:0] rd_data_out;
  wire [22:0] ext_address_lines_out;
  wire [1:0] ext_bank_address_lines_out, byte_enable_n_out;
  wire [15:0] ext_data_bus_in, ext_data_bus_out;
  wire ext_data_bus_oe_out, async_chip_select_n_out, async_output_enable_n_out;
  wire async_write_strobe_n_out, ext_wait_input_in;
  integer seed = 7890, num_errors = 0, check_count = 0, cycles = 0;
  logic [31:0] exp_q[$];
  logic [31:0] words[logic [22:0]];
  ams_sequencer i_ams_sequencer (.clk_in, .reset_in, .chip_space_config_in, .req_valid_in,
    .req_write_in, .req_addr_in, .req_bytes_in, .req_wdata_in, .req_taken_out, .req_done_out,
    .req_abandon_out, .rd_valid_out, .rd_ready_in, .rd_data_out, .ext_address_lines_out,
    .ext_bank_address_lines_out, .ext_data_bus_in, .ext_data_bus_out, .ext_data_bus_oe_out,
    .async_chip_select_n_out, .async_output_enable_n_out, .async_write_strobe_n_out,
    .byte_enable_n_out, .ext_wait_input_in, .busy_out);
  ams_mem_model i_ams_mem_model (.clk_in, .stretch_in(stretch), .addr_in(ext_address_lines_out),
    .bank_in(ext_bank_address_lines_out), .data_in(ext_data_bus_out),
    .cs_n_in(async_chip_select_n_out), .oe_n_in(async_output_enable_n_out),
    .we_n_in(async_write_strobe_n_out), .be_n_in(byte_enable_n_out),
    .data_out(ext_data_bus_in), .wait_out(ext_wait_input_in));
  // Clock
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  task check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Timing fields with a random strobe width; setup and hold one
  function automatic logic [31:0] conf(input logic ss, input logic [1:0] ta, input logic wide);
    logic [5:0] st;
    st = 6'($random(seed) & 3);
    return {ss, 1'b0, 4'h1, st, 3'h1, 4'h1, st, 3'h1, ta, 1'b0, wide};
  endfunction
  // One word request; lat counts cycles until the strobe falls
  task automatic access(input logic w, input logic [22:0] a, output int lat);
    logic [31:0] d;
    int n;
    d = $random(seed);
    lat = 0;
    n = 0;
    if (w) words[a] = d;
    else exp_q.push_back(words[a]);
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= w;
    req_addr_in <= a;
    req_wdata_in <= d;
    @(negedge clk_in);
    while (async_output_enable_n_out && async_write_strobe_n_out && lat < 200) begin
      @(negedge clk_in);
      lat++;
    end
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    while (req_done_out !== 1'b1 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    check(req_done_out, 1'b1);
  endtask
  task drain;
    repeat (200) if (exp_q.size() != 0) @(negedge clk_in);
  endtask
  // Read words leave the FIFO in request order
  always @(negedge clk_in) begin
    if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1)
      check(rd_data_out, exp_q.size() ? exp_q.pop_front() : 32'hX);
  end
  // Far-side stalls and the run ceiling
  always @(posedge clk_in) begin
    cycles++;
    rd_ready_in <= hold_rd ? 1'b0 : 1'($random(seed));
    if (cycles == 30000) begin
      num_errors++;
      stop_test;
    end
  end
  initial begin
    int l, lww, lrw, lrr, lwr, d0, n;
    logic seen;
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    // Every mode and bus width, writes then reads, two addresses
    for (int m = 0; m < 4; m++) begin
      chip_space_config_in <= conf(m[1], 2'h0, m[0]);
      access(1'b1, 23'h10, l);
      access(1'b1, 23'h20, l);
      access(1'b0, 23'h10, l);
      access(1'b0, 23'h20, l);
    end
    // Turnaround follows direction changes and the field
    for (int t = 0; t < 4; t += 2) begin
      chip_space_config_in <= conf(1'b0, 2'(t), 1'b1);
      access(1'b1, 23'h10, l);
      access(1'b1, 23'h10, lww);
      access(1'b0, 23'h10, lrw);
      access(1'b0, 23'h10, lrr);
      access(1'b1, 23'h10, lwr);
      check(lrw - lrr, lwr - lww);
      if (t == 0) d0 = lwr - lww;
      else check(lwr - lww - d0, 2);
    end
    check(d0 >= 1, 1);
    // Wait input raised during strobes; it arrives too late to stretch these short strobes
    stretch <= 1'b1;
    access(1'b1, 23'h10, l);
    access(1'b0, 23'h10, l);
    stretch <= 1'b0;
    // Request withdrawn during a long turnaround
    chip_space_config_in <= conf(1'b0, 2'h3, 1'b1);
    access(1'b0, 23'h10, l);
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= 1'b1;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    n = 0;
    while (req_abandon_out !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    check(req_abandon_out, 1'b1);
    // Fill the read FIFO until a request is refused, then drain it
    drain;
    hold_rd = 1'b1;
    repeat (8) access(1'b0, 23'h10, l);
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= 1'b0;
    seen = 1'b0;
    repeat (20) begin
      @(negedge clk_in);
      seen |= req_taken_out;
    end
    check(seen, 1'b0);
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    hold_rd = 1'b0;
    drain;
    check(exp_q.size(), 0);
    stop_test;
  end
endmodule // ams_sequencer_bench
